// File: irq_detect_pkg.sv
// Package for the external interrupt detect and acknowledge block.
// Assumes a single 50 MHz system clock; phase-1 timing comes from a divider.
package irq_detect_pkg;

    localparam int unsigned NUM_IRQ          = 4;
    localparam int unsigned CLK_PERIOD_NS    = 20;
    // Phase-1 period in ns; the falling edge is a one-cycle enable.
    localparam int unsigned PHASE1_PERIOD_NS = 40;
    localparam int unsigned PHASE1_DIV       =
        (PHASE1_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  IRQ_IDLE_N       = 4'hf;
    localparam logic [3:0]  FLAGS_RESET      = 4'h0;
    localparam logic [1:0]  REARM_PH1        = 2'h2;

    // Acknowledge pipeline position, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ACK_IDLE   = 2'b00,
        ACK_FETCH  = 2'b01,
        ACK_DECODE = 2'b11,
        ACK_READ   = 2'b10
    } ack_state_t;

    typedef struct packed {
        logic       fetch_boundary;
        logic       ack_fetched;
        logic [3:0] clear;
    } cpu_ctl_t;

endpackage : irq_detect_pkg

// File: phase1_div.sv
// Phase clock divider: one-cycle rise and fall enables of phase1_clock.
// Assumes PHASE1_DIV is at least 2.
`timescale 1ns/10ps
`default_nettype none
module phase1_div
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    output logic      phase1_clock,
    output logic      ph1_rise,
    output logic      ph1_fall
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic       next_clock;

    always_comb
    begin
        if (cnt == 8'(irq_detect_pkg::PHASE1_DIV - 1))
            next_cnt = 8'h00;
        else
            next_cnt = cnt + 8'h01;
        next_clock = (cnt == 8'h00);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt          <= 8'h00;
            phase1_clock <= 1'b0;
        end
        else
        begin
            cnt          <= next_cnt;
            phase1_clock <= next_clock;
        end
    end

    assign ph1_rise = (cnt == 8'h00);
    assign ph1_fall = (cnt == 8'h01);
endmodule : phase1_div
`default_nettype wire

// File: ext_irq_detect.sv
// External interrupt detect and acknowledge strobe logic.
// Assumes the CPU core supplies fetch boundaries, flag clears and the
// acknowledge instruction; pins may be asynchronous to sys_clk.
// Functional notes
// - Four active-low interrupt pins are synchronised inside the device.
// - Each pin works level- or edge-sensitive.
// - Pins are sampled only at the phase-1 falling edge.
// - The CPU sees requests (irq_taken) only at instruction-fetch boundaries.
// - Edge select 1 detects high-to-low transitions synchronously.
// - A flag may set again at the first phase-1 falling edge after clearing.
// - A clear coinciding with a low sample wins; flag stays clear.
// - A late pin change may be recognised one cycle later.
// - Acknowledge strobe goes active at phase-1 rise starting decode.
// - Acknowledge strobe goes inactive at phase-1 rise starting read.
// - Strobe pulses on each acknowledge instruction fetched while idle, serviced or not.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_detect
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic [3:0]              ext_irq_inputs_n,
    input  wire logic [3:0]              edge_select,
    input  wire irq_detect_pkg::cpu_ctl_t cpu_ctl,
    output logic                         phase1_clock,
    output logic [3:0]                   irq_flags,
    output logic [3:0]                   irq_taken,
    output logic                         irq_ack_strobe
);
    // =========================================================
    // Phase clock
    // =========================================================
    logic ph1_rise;
    logic ph1_fall;

    phase1_div u_div
    (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .phase1_clock (phase1_clock),
        .ph1_rise     (ph1_rise),
        .ph1_fall     (ph1_fall)
    );

    // =========================================================
    // Synchroniser and detection
    // =========================================================
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sampled;
    logic [3:0] next_sampled;
    logic [3:0] next_flags;
    logic [3:0] next_taken;
    logic [3:0] req;

    // A pin moving near the sampling edge may slip one cycle late.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= irq_detect_pkg::IRQ_IDLE_N;
            sync2 <= irq_detect_pkg::IRQ_IDLE_N;
        end
        else
        begin
            sync1 <= ext_irq_inputs_n;
            sync2 <= sync1;
        end
    end

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_chan
            always_comb
            begin
                // Level: low sample; edge: previous high, now low.
                if (edge_select[i])
                    req[i] = sampled[i] & ~sync2[i];
                else
                    req[i] = ~sync2[i];
                next_sampled[i] = ph1_fall ? sync2[i] : sampled[i];
                next_flags[i] = irq_flags[i];
                if (ph1_fall && req[i])
                    next_flags[i] = 1'b1;
                // Clear beats a coincident sample; re-arm after.
                if (cpu_ctl.clear[i])
                    next_flags[i] = 1'b0;
                next_taken[i] = cpu_ctl.fetch_boundary & irq_flags[i];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sampled   <= irq_detect_pkg::IRQ_IDLE_N;
            irq_flags <= irq_detect_pkg::FLAGS_RESET;
            irq_taken <= irq_detect_pkg::FLAGS_RESET;
        end
        else
        begin
            sampled   <= next_sampled;
            irq_flags <= next_flags;
            irq_taken <= next_taken;
        end
    end

    // =========================================================
    // Acknowledge strobe
    // =========================================================
    irq_detect_pkg::ack_state_t ack_state;
    irq_detect_pkg::ack_state_t next_ack_state;
    logic                       next_strobe;

    always_comb
    begin
        next_ack_state = ack_state;
        next_strobe    = irq_ack_strobe;
        case (ack_state)
            irq_detect_pkg::ACK_IDLE:
                // Any acknowledge instruction runs, serviced or not.
                if (cpu_ctl.ack_fetched)
                    next_ack_state = irq_detect_pkg::ACK_FETCH;
            irq_detect_pkg::ACK_FETCH:
                if (ph1_rise)
                begin
                    next_ack_state = irq_detect_pkg::ACK_DECODE;
                    next_strobe    = 1'b1;
                end
            irq_detect_pkg::ACK_DECODE:
                if (ph1_rise)
                begin
                    next_ack_state = irq_detect_pkg::ACK_READ;
                    next_strobe    = 1'b0;
                end
            irq_detect_pkg::ACK_READ:
                next_ack_state = irq_detect_pkg::ACK_IDLE;
            default:
                next_ack_state = irq_detect_pkg::ACK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_state      <= irq_detect_pkg::ACK_IDLE;
            irq_ack_strobe <= 1'b0;
        end
        else
        begin
            ack_state      <= next_ack_state;
            irq_ack_strobe <= next_strobe;
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    // Channels share one generate body, so a few bits stand for all four.
    a_flag_clear_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_ctl.clear[0] |=> !irq_flags[0])
        else $error("flag set despite clear");
    a_level_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ph1_fall && !edge_select[0] && !sync2[0] && !cpu_ctl.clear[0])
        |=> irq_flags[0])
        else $error("level sample did not set flag");
    a_edge_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!irq_flags[0] && edge_select[0] && ph1_fall && !sampled[0])
        |=> !irq_flags[0])
        else $error("edge mode set on held low");
    a_sample_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!ph1_fall && !irq_flags[1]) |=> !irq_flags[1])
        else $error("flag set outside sampling edge");
    a_taken_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_taken[0] |-> $past(cpu_ctl.fetch_boundary))
        else $error("taken outside fetch boundary");
    a_sync_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##2 sync2 == $past(ext_irq_inputs_n, 2))
        else $error("synchroniser delay wrong");
    a_strobe_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(irq_ack_strobe) |-> $past(ph1_rise))
        else $error("strobe rose off phase-1 rise");
    a_strobe_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(irq_ack_strobe) |-> $past(ph1_rise) && ack_state ==
        irq_detect_pkg::ACK_READ)
        else $error("strobe fell off read start");
    a_strobe_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ack_state == irq_detect_pkg::ACK_IDLE && cpu_ctl.ack_fetched)
        |-> ##[1:6] irq_ack_strobe)
        else $error("no strobe for acknowledge");
    a_strobe_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(irq_ack_strobe) |=> irq_ack_strobe ##1 !irq_ack_strobe)
        else $error("strobe not one phase-1 period");
    a_ph1_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ph1_rise |=> phase1_clock)
        else $error("phase-1 clock not high after rise");
    a_ph1_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ph1_fall |=> !phase1_clock)
        else $error("phase-1 clock not low after fall");
    a_edge_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ph1_fall && edge_select[1] && sampled[1] && !sync2[1]
        && !cpu_ctl.clear[1]) |=> irq_flags[1])
        else $error("edge mode missed a falling edge");
    a_taken_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_taken[3] |-> $past(irq_flags[3]))
        else $error("taken without a flag");

    c_level_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !edge_select[0] ##1 $rose(irq_flags[0]));
    c_edge_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
        edge_select[2] ##1 $rose(irq_flags[2]));
    c_clear_race: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cpu_ctl.clear[0] && ph1_fall && !sync2[0]);
    c_ack_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(irq_ack_strobe));
    c_taken: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(irq_taken[3]));
endmodule : ext_irq_detect
`default_nettype wire

// File: irq_source.sv
// Model of four external sources driving active-low request pins.
// Assumes fire is a one-cycle pulse per pin and hold is a level.
`timescale 1ns/10ps
`default_nettype none
module irq_source
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] fire,
    input  wire logic [3:0] hold,
    output logic [3:0]      ext_irq_inputs_n
);
    logic [1:0] cnt [4];
    // ==========================================
    // Pulse timing
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rst_n)
                cnt[i] <= 2'h0;
            else if (fire[i])
                cnt[i] <= 2'h3;
            else if (cnt[i] != 2'h0)
                cnt[i] <= cnt[i] - 2'h1;
        end
    end
    // Pins idle high, as with the board pull-up
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            ext_irq_inputs_n[i] = !(hold[i] || cnt[i] != 2'h0);
    end
endmodule : irq_source
`default_nettype wire

// File: tb.sv
// Self-checking testbench for ext_irq_detect.
// Assumes the package, design and source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                     sys_clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic [3:0]               fire = 4'h0;
    logic [3:0]               hold = 4'h0;
    logic [3:0]               pins_n;
    logic [3:0]               edge_select = 4'h0;
    irq_detect_pkg::cpu_ctl_t cpu_ctl = '0;
    logic                     ph1;
    logic [3:0]               flags;
    logic [3:0]               taken;
    logic                     ack;
    int                       failures = 0;
    int                       total_checks = 0;

    always #10 sys_clk = ~sys_clk;

    irq_source src (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire),
        .hold(hold), .ext_irq_inputs_n(pins_n));
    ext_irq_detect dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .ext_irq_inputs_n(pins_n), .edge_select(edge_select),
        .cpu_ctl(cpu_ctl), .phase1_clock(ph1), .irq_flags(flags),
        .irq_taken(taken), .irq_ack_strobe(ack));

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Bounded wait, so a dead flag shows as a mismatch and not a hang
    task automatic wait_flags(input logic [3:0] m);
        for (int n = 0; n < 12 && (flags & m) !== m; n++)
            tick(1);
    endtask : wait_flags

    task automatic clr(input logic [3:0] m);
        @(posedge sys_clk);
        cpu_ctl.clear <= m;
        @(posedge sys_clk);
        cpu_ctl.clear <= 4'h0;
        #1;
    endtask : clr

    task automatic pulse(input logic [3:0] m);
        @(posedge sys_clk);
        fire <= m;
        @(posedge sys_clk);
        fire <= 4'h0;
    endtask : pulse

    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // ==========================================
    // Scenarios
    task automatic t_level;
        edge_select <= 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            pulse(4'h1 << i);
            wait_flags(4'h1 << i);
            chk(flags, 4'h1 << i);
            tick(6);
            clr(4'hf);
            chk(flags, 4'h0);
        end
        $display("level test done");
    endtask : t_level

    task automatic t_rearm;
        @(posedge sys_clk);
        hold <= 4'h4;
        wait_flags(4'h4);
        clr(4'h4);
        chk(flags, 4'h0);
        wait_flags(4'h4);
        chk(flags, 4'h4);
        @(posedge sys_clk);
        hold <= 4'h0;
        tick(8);
        clr(4'hf);
        $display("rearm test done");
    endtask : t_rearm

    task automatic t_edge;
        @(posedge sys_clk);
        edge_select <= 4'h2;
        hold <= 4'h2;
        wait_flags(4'h2);
        chk(flags, 4'h2);
        clr(4'h2);
        tick(10);
        chk(flags, 4'h0);
        @(posedge sys_clk);
        hold <= 4'h0;
        tick(6);
        pulse(4'h2);
        wait_flags(4'h2);
        chk(flags, 4'h2);
        tick(6);
        clr(4'hf);
        $display("edge test done");
    endtask : t_edge

    task automatic t_fetch;
        edge_select <= 4'h0;
        pulse(4'h8);
        wait_flags(4'h8);
        tick(2);
        chk(taken, 4'h0);
        @(posedge sys_clk);
        cpu_ctl.fetch_boundary <= 1'b1;
        @(posedge sys_clk);
        cpu_ctl.fetch_boundary <= 1'b0;
        #1;
        chk(taken, 4'h8);
        tick(6);
        clr(4'hf);
        $display("fetch test done");
    endtask : t_fetch

    task automatic t_ack;
        int w;
        for (int k = 0; k < 2; k++)
        begin
            w = 0;
            @(posedge sys_clk);
            cpu_ctl.ack_fetched <= 1'b1;
            @(posedge sys_clk);
            cpu_ctl.ack_fetched <= 1'b0;
            for (int n = 0; n < 8 && ack !== 1'b1; n++)
                tick(1);
            chk({3'h0, ph1}, 4'h1);
            for (; w < 8 && ack === 1'b1; w++)
                tick(1);
            chk(4'(w), 4'h2);
        end
        $display("ack test done");
    endtask : t_ack

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({taken[1:0], ack, flags[0]}, 4'h0);
        t_level();
        t_rearm();
        t_edge();
        t_fetch();
        t_ack();
        stop_test();
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
